//--- inc/ifb_pkg.sv
// Types shared by the interrupt flag bank.
package ifb_pkg;

    // =====================================================================
    // Peripheral event strobes, one cycle each.
    typedef struct packed
    {
        logic parallel_port;
        logic compare_ch5;
        logic capture_ch5;
        logic capture_ch4;
        logic capture_ch3;
        logic serial_port2_event;
        logic serial_port2_fault;
        logic calendar;
        logic twowire2_master;
        logic twowire2_slave;
    } ifb_events_t;

    // =====================================================================
    // Classic Wishbone slave request.
    typedef struct packed
    {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ifb_wb_req_t;

endpackage

//--- inc/ifb_regs.svh
// Register offsets, field positions and reset values of the interrupt flag bank.
`ifndef IFB_REGS_SVH
`define IFB_REGS_SVH

// =====================================================================
// Register byte offsets
`define IFB_OFS_FLAGS2      8'h00
`define IFB_OFS_FLAGS3      8'h04
`define IFB_OFS_MASK2       8'h08
`define IFB_OFS_MASK3       8'h0C

// =====================================================================
// Field positions of the second flag register
`define IFB_F2_PARALLEL     13
`define IFB_F2_COMPARE5     9
`define IFB_F2_CAPTURE5     7
`define IFB_F2_CAPTURE4     6
`define IFB_F2_CAPTURE3     5
`define IFB_F2_SPI2_EVENT   1
`define IFB_F2_SPI2_FAULT   0

// =====================================================================
// Field positions of the third flag register
`define IFB_F3_CALENDAR     14
`define IFB_F3_I2C2_MASTER  2
`define IFB_F3_I2C2_SLAVE   1

// =====================================================================
// Implemented-bit masks and reset values
`define IFB_IMPL2           16'h22E3
`define IFB_IMPL3           16'h4006
`define IFB_RST_FLAGS       16'h0000
`define IFB_RST_MASK        16'h0000

`endif

//--- test/ifb_flag_bank_checker.sv
// Port assertions for the interrupt flag bank.
`timescale 1ns/1ps
module ifb_chk
    import ifb_pkg::*;
(
    // Clock, reset and enable
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        clk_en,
    // Inputs of the bank
    input wire ifb_events_t events,
    input wire ifb_wb_req_t wb_req,
    // Outputs of the bank
    input wire logic        wb_ack,
    input wire logic        irq,
    input wire logic [31:0] wb_dat_o
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire req = wb_req.cyc & wb_req.stb & clk_en;
    wire wr  = wb_req.cyc & wb_req.we;
    ack_after_req_a: assert property (req && !wb_ack |=> wb_ack) else $error("ack late");
    ack_single_a: assert property (wb_ack && clk_en |=> !wb_ack) else $error("ack long");
    ack_cause_a: assert property (!wb_req.stb && clk_en |=> !wb_ack) else $error("ack odd");
    dat_idle_a: assert property (!wb_ack |-> wb_dat_o == 0) else $error("dat odd");
    unused_two_a: assert property (wb_ack && $past(wb_req.adr) == 8'h00 |->
        (wb_dat_o & 32'hFFFF_DD1C) == 0) else $error("flags2 unused");
    unused_three_a: assert property (wb_ack && $past(wb_req.adr) == 8'h04 |->
        (wb_dat_o & 32'hFFFF_BFF9) == 0) else $error("flags3 unused");
    irq_hold_a: assert property (irq && clk_en && !wr |=> irq) else $error("irq fell");
    irq_cause_a: assert property (!irq && clk_en && !wr && events == 0 |=> !irq)
        else $error("irq rose");
    cover property ($rose(irq));
    cover property (wb_ack && wb_dat_o != 0);
    cover property (req && wr);
endmodule
bind ifb_flag_bank ifb_chk i_chk (.clk_sys, .reset_n, .clk_en, .events, .wb_req, .wb_ack,
    .irq, .wb_dat_o);

//--- test/ifb_flag_bank_test.sv
// Self-checking bench for the interrupt flag bank.
`timescale 1ns/1ps
module ifb_flag_bank_test
    import ifb_pkg::*;
;
    logic        clk_sys, reset_n, clk_en, wb_ack, irq;
    ifb_events_t events;
    ifb_wb_req_t wb_req;
    logic [31:0] wb_dat_o, q;
    int          err_total, checks_done;
    ifb_flag_bank i_dut (.clk_sys, .reset_n, .clk_en, .events, .wb_req, .wb_ack, .wb_dat_o, .irq);
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus_lane(input logic we, input logic [7:0] a, input logic [15:0] d,
                  input logic [3:0] s);
        wb_req <= '{1'b1, 1'b1, we, s, a, {16'h0000, d}};
        do @(posedge clk_sys); while (wb_ack !== 1'b1);
        q = wb_dat_o;
        wb_req <= '0;
        @(posedge clk_sys);
    endtask
    task bus(input logic we, input logic [7:0] a, input logic [15:0] d);
        bus_lane(we, a, d, 4'h3);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(q, {16'h0000, e});
    endtask
    task automatic t_events;
        int         pos [10] = '{13, 9, 7, 6, 5, 1, 0, 14, 2, 1};
        logic [7:0] adr;
        for (int i = 0; i < 10; i++)
        begin
            adr = (i < 7) ? 8'h00 : 8'h04;
            events <= 10'h200 >> i;
            @(posedge clk_sys);
            events <= '0;
            rd(adr, 16'h0001 << pos[i]);
            bus(1'b1, adr, 16'h0000);
            rd(adr, 16'h0000);
        end
        $display("event test done");
    endtask
    task t_write;
        rd(8'h08, 16'h0000);
        bus(1'b1, 8'h04, 16'hFFFF);
        rd(8'h04, 16'h4006);
        bus(1'b1, 8'h00, 16'hFFFF);
        rd(8'h00, 16'h22E3);
        bus(1'b1, 8'h10, 16'hFFFF);
        rd(8'h10, 16'h0000);
        bus(1'b1, 8'h00, 16'h0000);
        bus(1'b1, 8'h04, 16'h0000);
        $display("write test done");
    endtask
    task t_irq;
        bus(1'b1, 8'h08, 16'h0020);
        events <= 10'h020;
        @(posedge clk_sys);
        events <= '0;
        @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, 8'h08, 16'h0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        bus(1'b1, 8'h08, 16'h0020);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, 8'h00, 16'h0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        $display("irq test done");
    endtask
    task t_lanes;
        bus_lane(1'b1, 8'h0C, 16'hFFFF, 4'h2);
        rd(8'h0C, 16'h4000);
        bus_lane(1'b1, 8'h0C, 16'hFFFF, 4'h1);
        rd(8'h0C, 16'h4006);
        events <= 10'h002;
        @(posedge clk_sys);
        events <= '0;
        @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        bus_lane(1'b1, 8'h04, 16'h0000, 4'h2);
        rd(8'h04, 16'h0004);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        bus_lane(1'b1, 8'h04, 16'h0000, 4'h1);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        bus(1'b1, 8'h0C, 16'h0000);
        $display("lane test done");
    endtask
    task t_collide;
        fork
            bus(1'b1, 8'h00, 16'h0000);
            begin
                events <= 10'h100;
                @(posedge clk_sys);
                events <= '0;
            end
        join
        rd(8'h00, 16'h0200);
        bus(1'b1, 8'h00, 16'h0000);
        rd(8'h00, 16'h0000);
        $display("collision test done");
    endtask
    task t_enable;
        clk_en <= 1'b0;
        events <= 10'h004;
        @(posedge clk_sys);
        events <= '0;
        clk_en <= 1'b1;
        @(posedge clk_sys);
        rd(8'h04, 16'h0000);
        $display("enable test done");
    endtask
    task t_reset;
        bus(1'b1, 8'h00, 16'hFFFF);
        bus(1'b1, 8'h08, 16'h2000);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(8'h00, 16'h0000);
        rd(8'h08, 16'h0000);
        $display("reset test done");
    endtask
    task conclude;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        reset_n <= 1'b0;
        clk_en <= 1'b1;
        events <= '0;
        wb_req <= '0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_events;
        t_write;
        t_irq;
        t_lanes;
        t_collide;
        t_enable;
        t_reset;
        conclude;
    end
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        conclude;
    end
endmodule

//--- verilog/ifb_flag_bank.sv
// Interrupt flag bank with a classic Wishbone register slave.
//
// Functional notes
// - A flag reads 1 after, with clk_en high, its source requested an interrupt or software wrote 1 to it, else 0.
// - Second flag register bit 13 holds the parallel port flag.
// - Second flag register bit 9 holds the compare channel 5 flag.
// - Second flag register bits 7, 6, 5 hold capture channels 5, 4, 3.
// - Second flag register bit 1 is serial port 2 event, bit 0 its fault.
// - Third flag register bit 14 holds the calendar flag.
// - Third flag register bit 2 holds the two-wire port 2 master flag.
// - Third flag register bit 1 holds the two-wire port 2 slave flag.
// - Unused flag bits always read as zero.
`timescale 1ns/1ps
`include "ifb_regs.svh"

module ifb_flag_bank
    import ifb_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Peripheral events
    input  wire ifb_events_t events,
    // Wishbone slave
    input  wire ifb_wb_req_t wb_req,
    output logic             wb_ack,
    output logic [31:0]      wb_dat_o,
    // Interrupt
    output logic             irq
);

    // =====================================================================
    // Register state
    logic [15:0] irq_flags_second;
    logic [15:0] irq_flags_third;
    logic [15:0] mask_second;
    logic [15:0] mask_third;

    // =====================================================================
    // Event placement into register layout
    wire [15:0] evt2;
    wire [15:0] evt3;

    assign evt2 = (16'(events.parallel_port)      << `IFB_F2_PARALLEL)
                | (16'(events.compare_ch5)        << `IFB_F2_COMPARE5)
                | (16'(events.capture_ch5)        << `IFB_F2_CAPTURE5)
                | (16'(events.capture_ch4)        << `IFB_F2_CAPTURE4)
                | (16'(events.capture_ch3)        << `IFB_F2_CAPTURE3)
                | (16'(events.serial_port2_event) << `IFB_F2_SPI2_EVENT)
                | (16'(events.serial_port2_fault) << `IFB_F2_SPI2_FAULT);
    assign evt3 = (16'(events.calendar)           << `IFB_F3_CALENDAR)
                | (16'(events.twowire2_master)    << `IFB_F3_I2C2_MASTER)
                | (16'(events.twowire2_slave)     << `IFB_F3_I2C2_SLAVE);

    // =====================================================================
    // Bus decode
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    wire        req     = wb_req.cyc & wb_req.stb & ~wb_ack;
    wire        wr      = req & wb_req.we;
    wire [15:0] bmask   = lane_mask(wb_req.sel);
    wire [15:0] wdat    = wb_req.dat[15:0];
    wire        hit_f2  = wb_req.adr == `IFB_OFS_FLAGS2;
    wire        hit_f3  = wb_req.adr == `IFB_OFS_FLAGS3;
    wire        hit_m2  = wb_req.adr == `IFB_OFS_MASK2;
    wire        hit_m3  = wb_req.adr == `IFB_OFS_MASK3;

    // Software writes both set and clear; a hardware event wins over a clear.
    wire [15:0] sw2 = (wr & hit_f2) ? ((irq_flags_second & ~bmask) | (wdat & bmask))
                                    : irq_flags_second;
    wire [15:0] sw3 = (wr & hit_f3) ? ((irq_flags_third & ~bmask) | (wdat & bmask))
                                    : irq_flags_third;
    wire [15:0] next_flags2 = (sw2 | evt2) & `IFB_IMPL2;
    wire [15:0] next_flags3 = (sw3 | evt3) & `IFB_IMPL3;
    wire [15:0] next_mask2  = (wr & hit_m2) ? ((mask_second & ~bmask) | (wdat & bmask)
                                               & `IFB_IMPL2) : mask_second;
    wire [15:0] next_mask3  = (wr & hit_m3) ? ((mask_third & ~bmask) | (wdat & bmask)
                                               & `IFB_IMPL3) : mask_third;

    wire [15:0] rd_sel = hit_f2 ? irq_flags_second
                       : hit_f3 ? irq_flags_third
                       : hit_m2 ? mask_second
                       : hit_m3 ? mask_third
                       : 16'h0000;
    wire        next_irq = |((next_flags2 & next_mask2) | (next_flags3 & next_mask3));

    // =====================================================================
    // Registers
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            irq_flags_second <= `IFB_RST_FLAGS;
            irq_flags_third  <= `IFB_RST_FLAGS;
            mask_second      <= `IFB_RST_MASK;
            mask_third       <= `IFB_RST_MASK;
            wb_ack           <= 1'b0;
            wb_dat_o         <= 32'h0000_0000;
            irq              <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_flags_second <= next_flags2;
            irq_flags_third  <= next_flags3;
            mask_second      <= next_mask2;
            mask_third       <= next_mask3;
            wb_ack           <= req;
            wb_dat_o         <= req ? {16'h0000, rd_sel} : 32'h0000_0000;
            irq              <= next_irq;
        end
    end

endmodule
